// ==== pkg/lds_pkg.sv ====
package lds_pkg;
  localparam logic [6:0] DEV_ADDR      = 7'h1b;
  localparam logic [4:0] ADDR_ENABLE   = 5'h10;
  localparam logic [4:0] ADDR_STATUS   = 5'h11;
  localparam logic [4:0] ADDR_PWM1     = 5'h08;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam int         STAT_OT_BIT   = 0;
  localparam int         STAT_LP_BIT   = 2;
  localparam int         CLK_MHZ       = 100;
  localparam int         LP_IDLE_US    = 5000;
  localparam int         LP_IDLE_CYC   = LP_IDLE_US * CLK_MHZ;

  typedef enum logic [2:0] {
    CC_APPLY    = 3'h0,
    CC_WRITE    = 3'h1,
    CC_WR_APPLY = 3'h2,
    CC_ALL_CUR  = 3'h3,
    CC_ALL_PWM  = 3'h4
  } lds_code_e;

  typedef enum logic [1:0] {
    PM_1X  = 2'h0,
    PM_1P33 = 2'h1,
    PM_1P5 = 2'h2,
    PM_2X  = 2'h3
  } lds_pump_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h2,
    ST_CTRL = 4'h3,
    ST_CACK = 4'h4,
    ST_DATA = 4'h5,
    ST_DACK = 4'h6,
    ST_TX   = 4'h7,
    ST_TACK = 4'h8
  } lds_state_e;

  typedef struct packed {
    logic       over_temp;
    logic       bias_oc;
    logic       pump_ovp;
    logic [7:0] pump_short;
  } lds_fault_s;

  typedef struct packed {
    logic [2:0] code;
    logic [4:0] addr;
  } lds_ctrl_s;
endpackage

// ==== logic/lds_regmem.sv ====
`timescale 1ns/1ps
module lds_regmem #(
  parameter int CH = 8,
  parameter int W  = 8
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // Staging writes
  input  wire logic                wr_en,
  input  wire logic [3:0]          wr_idx,
  input  wire logic                fill_cur,
  input  wire logic                fill_pwm,
  input  wire logic [W-1:0]        wr_data,
  input  wire logic                apply,
  // Read port and active settings
  input  wire logic [3:0]          rd_idx,
  output logic      [W-1:0]        rd_data_q,
  output logic      [2*CH*W-1:0]   active_q
);
  logic [W-1:0] stage_q [2*CH];

  // Staged values stay invisible to the channels until an apply copies them
  for (genvar i = 0; i < 2*CH; i++) begin : g_reg
    wire hit = (wr_en && wr_idx == 4'(i)) || (fill_cur && i < CH) || (fill_pwm && i >= CH);
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        stage_q[i] <= '0;
        active_q[i*W +: W] <= '0;
      end else begin
        if (hit) stage_q[i] <= wr_data;
        if (apply) active_q[i*W +: W] <= stage_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rd_data_q <= '0;
    else rd_data_q <= stage_q[rd_idx];
  end
endmodule // lds_regmem

// ==== logic/lds_top.sv ====
`timescale 1ns/1ps
module lds_top #(
  parameter int CH      = 8,
  parameter int IDLE_CYC = lds_pkg::LP_IDLE_CYC
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  // Serial bus pins
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  // Analogue detectors
  input  wire lds_pkg::lds_fault_s   fault_i,
  input  wire logic [1:0]            pump_mode_req,
  input  wire logic                  chip_ready,
  // Channel and supply controls
  output logic      [CH-1:0]         led_on_q,
  output logic                       ref_en_q,
  output logic                       pump_en_q,
  output lds_pkg::lds_pump_e         pump_mode_q,
  output logic                       low_power_q,
  output logic      [2*CH*8-1:0]     active_cfg
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0]          scl_r, sda_r;
  lds_pkg::lds_fault_s flt_m, flt;
  logic [1:0]          pmr_m, pmr;
  logic                rdy_m, rdy;
  logic                scl_d, sda_d;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_r <= 2'h3;
      sda_r <= 2'h3;
      {flt_m, flt, pmr_m, pmr, rdy_m, rdy} <= '0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_r <= {scl_r[0], scl_i};
      sda_r <= {sda_r[0], sda_i};
      {flt_m, pmr_m, rdy_m} <= {fault_i, pump_mode_req, chip_ready};
      {flt, pmr, rdy} <= {flt_m, pmr_m, rdy_m};
      scl_d <= scl_r[1];
      sda_d <= sda_r[1];
    end
  end

  wire scl      = scl_r[1];
  wire sda      = sda_r[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire bus_start = scl & scl_d & sda_d & ~sda;
  wire bus_stop  = scl & scl_d & ~sda_d & sda;

  ////////////////////////////////////////////////////////////////////////
  // Bus target state machine
  lds_pkg::lds_state_e st_q;
  lds_pkg::lds_ctrl_s  ctl_q;
  logic [7:0] sr_q, tx_q, mask_q, applied_q;
  logic [3:0] cnt_q;
  logic [4:0] ptr_q;
  logic       rd_q, sda_oe_q;
  logic [7:0] mem_rd;
  logic [7:0] status;

  wire        byte_done = scl_fall && cnt_q == 4'h8;
  wire        addr_hit  = sr_q[7:1] == lds_pkg::DEV_ADDR;
  wire        data_wr   = st_q == lds_pkg::ST_DATA && byte_done;
  wire        ctrl_done = st_q == lds_pkg::ST_CTRL && byte_done;
  wire [2:0]  code      = ctl_q.code;
  wire        apply_now = (ctrl_done && sr_q[7:5] == lds_pkg::CC_APPLY) ||
                          (data_wr && code == lds_pkg::CC_WR_APPLY);
  wire        wr_single = data_wr && (code == lds_pkg::CC_WRITE ||
                                      code == lds_pkg::CC_WR_APPLY);
  wire        mask_wr   = wr_single && ctl_q.addr == lds_pkg::ADDR_ENABLE;
  wire        mem_wr    = wr_single && !ctl_q.addr[4];
  wire [7:0]  rd_byte   = ptr_q == lds_pkg::ADDR_ENABLE ? mask_q :
                          ptr_q == lds_pkg::ADDR_STATUS ? status :
                          ptr_q[4] ? 8'h00 : mem_rd;
  // The new mask is used in the same cycle as it is loaded by a 010 frame
  wire [7:0]  mask_nx   = mask_wr ? sr_q : mask_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= lds_pkg::ST_IDLE;
      ctl_q <= '0;
      {sr_q, tx_q, cnt_q, ptr_q, rd_q, sda_oe_q} <= '0;
    end else if (bus_start) begin
      st_q <= lds_pkg::ST_ADDR;
      cnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      st_q <= lds_pkg::ST_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      if (scl_rise) begin
        sr_q <= {sr_q[6:0], sda};
        cnt_q <= cnt_q + 4'h1;
      end
      if (scl_fall) begin
        case (st_q)
          lds_pkg::ST_ADDR: if (cnt_q == 4'h8) begin
            st_q <= addr_hit ? lds_pkg::ST_AACK : lds_pkg::ST_IDLE;
            sda_oe_q <= addr_hit;
            rd_q <= sr_q[0];
            cnt_q <= 4'h0;
          end
          lds_pkg::ST_AACK: begin
            st_q <= rd_q ? lds_pkg::ST_TX : lds_pkg::ST_CTRL;
            tx_q <= rd_byte;
            sda_oe_q <= rd_q & ~rd_byte[7];
            cnt_q <= 4'h0;
          end
          lds_pkg::ST_CTRL: if (cnt_q == 4'h8) begin
            st_q <= lds_pkg::ST_CACK;
            ctl_q <= sr_q;
            if (sr_q[7:5] == lds_pkg::CC_WRITE) ptr_q <= sr_q[4:0];
            sda_oe_q <= 1'b1;
            cnt_q <= 4'h0;
          end
          lds_pkg::ST_CACK, lds_pkg::ST_DACK: begin
            st_q <= lds_pkg::ST_DATA;
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
          end
          lds_pkg::ST_DATA: if (cnt_q == 4'h8) begin
            st_q <= lds_pkg::ST_DACK;
            sda_oe_q <= 1'b1;
            cnt_q <= 4'h0;
          end
          lds_pkg::ST_TX: if (cnt_q == 4'h8) begin
            st_q <= lds_pkg::ST_TACK;
            sda_oe_q <= 1'b0;
            cnt_q <= 4'h0;
          end else begin
            sda_oe_q <= ~tx_q[6];
            tx_q <= {tx_q[6:0], 1'b0};
          end
          lds_pkg::ST_TACK: begin
            // A not-acknowledge releases the bus; the stop follows from the master
            st_q <= sr_q[0] ? lds_pkg::ST_IDLE : lds_pkg::ST_TX;
            tx_q <= rd_byte;
            sda_oe_q <= ~sr_q[0] & ~rd_byte[7];
            cnt_q <= 4'h0;
          end
          default: ;
        endcase
      end
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_q;

  lds_regmem #(.CH(CH), .W(8)) u_mem (
    .clk       (core_clk),
    .arst_n    (arst_n),
    .wr_en     (mem_wr),
    .wr_idx    (ctl_q.addr[3:0]),
    .fill_cur  (data_wr && code == lds_pkg::CC_ALL_CUR),
    .fill_pwm  (data_wr && code == lds_pkg::CC_ALL_PWM),
    .wr_data   (sr_q),
    .apply     (apply_now),
    .rd_idx    (ptr_q[3:0]),
    .rd_data_q (mem_rd),
    .active_q  (active_cfg)
  );

  ////////////////////////////////////////////////////////////////////////
  // Channel enables, faults and low power
  logic [31:0] idle_q;
  logic        wake_q;
  wire         traffic = bus_start | scl_rise | scl_fall;
  wire         idle_hit = idle_q >= 32'(IDLE_CYC - 1);

  assign status = {5'h00, low_power_q, 1'b0, flt.over_temp};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= lds_pkg::MASK_RESET;
      applied_q <= lds_pkg::MASK_RESET;
      led_on_q <= '0;
      ref_en_q <= 1'b0;
      pump_en_q <= 1'b0;
      pump_mode_q <= lds_pkg::PM_1X;
      idle_q <= '0;
      low_power_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      mask_q <= mask_nx;
      if (apply_now) applied_q <= mask_nx;
      // Bit n drives channel n+1; a short on one channel spares the others
      led_on_q <= applied_q & ~flt.pump_short &
                  {CH{~flt.over_temp & ~flt.bias_oc}};
      ref_en_q <= ~flt.bias_oc;
      pump_en_q <= ~flt.over_temp;
      pump_mode_q <= flt.pump_ovp ? lds_pkg::PM_1X : lds_pkg::lds_pump_e'(pmr);
      idle_q <= (traffic || applied_q != 8'h00) ? 32'h0 :
                (idle_hit ? idle_q : idle_q + 32'h1);
      if (!low_power_q && idle_hit && applied_q == 8'h00) low_power_q <= 1'b1;
      if (low_power_q && traffic) wake_q <= 1'b1;
      if (wake_q && rdy) begin
        low_power_q <= 1'b0;
        wake_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_ack_entry;
    $rose(st_q == lds_pkg::ST_AACK);
  endsequence

  sequence s_apply_done;
    apply_now ##1 1'b1;
  endsequence

  // Written byte seen straight from the shifter, not through the mask mux
  sequence s_mask_frame;
    data_wr && code == lds_pkg::CC_WR_APPLY && ctl_q.addr == lds_pkg::ADDR_ENABLE;
  endsequence

  addr_ack_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_ack_entry |-> sda_oe_q && $past(sr_q[7:1]) == 7'h1b)
    else $error("address acknowledged for wrong address");
  mask_apply_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_apply_done |-> applied_q == mask_q)
    else $error("applied mask differs from loaded mask");
  mask_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_mask_frame |=> applied_q == $past(sr_q))
    else $error("enable byte not applied by write-and-apply frame");
  hold_load_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !apply_now |=> $stable(applied_q))
    else $error("enables changed without apply");
  ot_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    flt.over_temp |=> led_on_q == '0 && !pump_en_q)
    else $error("outputs on during over-temperature");
  bias_oc_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    flt.bias_oc |=> led_on_q == '0 && !ref_en_q)
    else $error("outputs on during bias over-current");
  short_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    ##1 (led_on_q & $past(flt.pump_short)) == '0)
    else $error("shorted channel left on");
  chan_map_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    ##1 (led_on_q & ~$past(applied_q)) == '0)
    else $error("disabled channel turned on");
  ovp_mode_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    flt.pump_ovp |=> pump_mode_q == lds_pkg::PM_1X)
    else $error("pump not back in 1x on overvoltage");
  status_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    status[0] == flt.over_temp && status[7:3] == 5'h00 && !status[1])
    else $error("status byte wrong");
  lp_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(low_power_q) |-> $past(rdy) && $past(wake_q))
    else $error("low-power flag cleared before ready");
  lp_enter_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(low_power_q) |-> $past(applied_q) == 8'h00 && $past(idle_hit))
    else $error("low power entered early");
  tx_first_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(st_q == lds_pkg::ST_TX) |-> sda_oe_q == ~tx_q[7])
    else $error("first read bit not driven");
endmodule // lds_top

// ==== tb/lds_master.sv ====
`timescale 1ns/1ps
module lds_master (
  // Clock and bus wire
  input  wire logic clk,
  input  wire logic sda,
  // Driven pins
  output logic      scl,
  output logic      sda_low
);
  logic [7:0] rd_byte;
  event       got;

  // Bus clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Data changes only mid-low so the target never sees a false start
  task automatic q();
    repeat (4) @(posedge clk);
  endtask

  task automatic put(input logic b, output logic r);
    q();
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
  endtask

  task automatic start();
    q();
    sda_low <= 1'b0;
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
  endtask

  task automatic stop();
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask

  task automatic send8(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put(d[i], r);
    end
    put(1'b1, r);
    ack = !r;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic wr(input logic [6:0] dev, input logic [2:0] cc, input logic [4:0] a,
                    input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    send8({dev, 1'b0}, k0);
    send8({cc, a}, k1);
    send8(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  task automatic rd(input logic [4:0] a);
    logic k0, k1, k2, r;
    start();
    send8({7'h1b, 1'b0}, k0);
    send8({3'h1, a}, k1);
    start();
    send8({7'h1b, 1'b1}, k2);
    for (int i = 0; i < 8; i++) begin
      put(1'b1, r);
      rd_byte = {rd_byte[6:0], r};
    end
    put(1'b1, r);
    stop();
    -> got;
  endtask
endmodule // lds_master

// ==== tb/test_led_driver_serial_control_status.sv ====
`timescale 1ns/1ps
module test_led_driver_serial_control_status;
  localparam int IDLE = 50;
  logic                core_clk;
  logic                arst_n;
  logic                scl;
  logic                m_low;
  logic                sda_oe;
  wire logic           sda;
  lds_pkg::lds_fault_s fault;
  logic [1:0]          pump_req;
  logic                ready;
  logic [7:0]          led;
  logic                ref_en;
  logic                pump_en;
  lds_pkg::lds_pump_e  pump_mode;
  logic                lp;
  logic [127:0]        cfg;
  logic [127:0]        exp_q[$];
  logic [31:0]         seed;
  logic                ok;
  int                  num_errors;
  int                  n_checks;

  // Open-drain data line with pull-up
  assign sda = !(m_low || sda_oe);

  lds_master m (.clk(core_clk), .sda(sda), .scl(scl), .sda_low(m_low));

  lds_top #(.CH(8), .IDLE_CYC(IDLE)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(),
    .sda_oe(sda_oe), .fault_i(fault), .pump_mode_req(pump_req), .chip_ready(ready),
    .led_on_q(led), .ref_en_q(ref_en), .pump_en_q(pump_en), .pump_mode_q(pump_mode),
    .low_power_q(lp), .active_cfg(cfg)
  );

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Every read byte is matched against the oldest expectation
  initial forever begin
    @(m.got);
    check("read byte", {120'h0, m.rd_byte}, exp_q.pop_front());
  end

  initial begin
    #400us;
    num_errors++;
    report_and_stop();
  end

  initial begin
    arst_n = 1'b0;
    fault = '0;
    pump_req = 2'h0;
    ready = 1'b1;
    seed = 32'h14176c7e;
    num_errors = 0;
    n_checks = 0;
    cyc(20);
    check("led in reset", led, 8'h00);
    check("oe in reset", sda_oe, 1'b0);
    check("mode in reset", pump_mode, lds_pkg::PM_1X);
    arst_n <= 1'b1;
    cyc(6);
    check("supplies on", {ref_en, pump_en}, 2'b11);
    $display("test reset done");

    ready <= 1'b0;
    cyc(IDLE + 10);
    check("low power", lp, 1'b1);
    exp_q.push_back(128'h04);
    m.rd(5'h11);
    check("wake held", lp, 1'b1);
    ready <= 1'b1;
    cyc(6);
    check("wake done", lp, 1'b0);
    exp_q.push_back(128'h00);
    m.rd(5'h11);
    $display("test low power done");

    // Random current and PWM values prove that staged settings stay parked
    seed = lfsr(seed);
    m.wr(7'h1b, 3'h1, 5'h10, 8'h8f, ok);
    check("ack", ok, 1'b1);
    m.wr(7'h1b, 3'h4, 5'h00, seed[7:0], ok);
    m.wr(7'h1b, 3'h3, 5'h00, seed[15:8], ok);
    m.wr(7'h1b, 3'h5, 5'h10, 8'h00, ok);
    cyc(8);
    check("staged led", led, 8'h00);
    check("staged cfg", cfg, 128'h0);
    m.wr(7'h1b, 3'h0, 5'h00, 8'h00, ok);
    cyc(8);
    check("applied led", led, 8'h8f);
    check("applied cfg", cfg, {{8{seed[7:0]}}, {8{seed[15:8]}}});
    exp_q.push_back({120'h0, seed[7:0]});
    m.rd(5'h08);
    m.wr(7'h1b, 3'h2, 5'h10, 8'h70, ok);
    cyc(8);
    check("write apply", led, 8'h70);
    m.wr(7'h1c, 3'h2, 5'h10, 8'hff, ok);
    check("foreign ack", ok, 1'b0);
    exp_q.push_back(128'h70);
    m.rd(5'h10);
    $display("test codes done");

    m.wr(7'h1b, 3'h2, 5'h10, 8'hff, ok);
    // Random shorted channel and pump request; over_temp, bias_oc and pump_ovp take fixed values
    seed = lfsr(seed);
    fault <= lds_pkg::lds_fault_s'({3'h0, 8'h01 << seed[2:0]});
    pump_req <= (seed[4:3] == 2'h0) ? 2'h3 : seed[4:3];
    cyc(6);
    check("short off", led, 8'(~(8'h01 << seed[2:0])));
    check("pump mode", pump_mode, (seed[4:3] == 2'h0) ? 2'h3 : seed[4:3]);
    fault <= lds_pkg::lds_fault_s'(11'h100);
    cyc(6);
    check("ovp mode", pump_mode, lds_pkg::PM_1X);
    check("short gone", led, 8'hff);
    fault <= lds_pkg::lds_fault_s'({3'h2, seed[12:5]});
    cyc(6);
    check("bias off", {ref_en, led}, 9'h000);
    fault <= lds_pkg::lds_fault_s'({3'h4, seed[20:13]});
    cyc(6);
    check("hot off", {pump_en, led}, 9'h000);
    exp_q.push_back(128'h01);
    m.rd(5'h11);
    fault <= '0;
    cyc(6);
    check("cool on", led, 8'hff);
    exp_q.push_back(128'h00);
    m.rd(5'h11);
    $display("test faults done");
    cyc(20);
    report_and_stop();
  end
endmodule // test_led_driver_serial_control_status
